/* verilog/mre_pkg.sv */
// Package for the move/return instruction executor: encodings, register map,
// field positions and reset values. Assumes a 14-bit instruction word.
// What this block does
// RL1: Literal load sets bank select, flags untouched
// RL2: Seven-bit literal loads pc high latch
// RL3: Eight-bit literal loads working register, one cycle
// RL4: Working register stored to file, one cycle
// RL5: Indirect store through either of two pointers
// RL6: Mode codes: preinc, predec, postinc, postdec
// RL7: Signed offset -32..31 added, pointer kept
// RL8: Pointer ends plus one, minus one, unchanged
// RL9: Sixteen-bit pointer wraps at both ends
// RL10: Pointer update and store leave flags alone
// RL11: Option load copies working register
// RL12: Software reset acts as hardware reset, flags cause
// RL13: Irq return pops stack, sets enable, two cycles
// RL14: Subroutine return pops stack, two cycles
// RL15: No-operation changes nothing but program counter
package mre_pkg;
  localparam int IW = 14;
  // Instruction encodings and their match masks
  localparam logic [13:0] OP_IDLE = 14'h0000;
  localparam logic [13:0] OP_RESET = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETIRQ = 14'h0009;
  localparam logic [13:0] OP_OPTION = 14'h0062;
  localparam logic [13:0] OP_ST_IND = 14'h0018;
  localparam logic [13:0] MSK_ST_IND = 14'h3FF8;
  localparam logic [13:0] OP_ST_FILE = 14'h0080;
  localparam logic [13:0] MSK_ST_FILE = 14'h3F80;
  localparam logic [13:0] OP_LD_BANK = 14'h0020;
  localparam logic [13:0] MSK_LD_BANK = 14'h3FE0;
  localparam logic [13:0] OP_LD_PAGE = 14'h3180;
  localparam logic [13:0] MSK_LD_PAGE = 14'h3F80;
  localparam logic [13:0] OP_LD_WORK = 14'h3000;
  localparam logic [13:0] MSK_LD_WORK = 14'h3F00;
  localparam logic [13:0] OP_ST_REL = 14'h3F80;
  localparam logic [13:0] MSK_ST_REL = 14'h3F80;
  // Operand field positions
  localparam int SEL_BIT_PLAIN = 2;
  localparam int SEL_BIT_REL = 6;
  // Pointer mode codes
  localparam logic [1:0] MODE_PREINC = 2'h0;
  localparam logic [1:0] MODE_PREDEC = 2'h1;
  localparam logic [1:0] MODE_POSTINC = 2'h2;
  localparam logic [1:0] MODE_POSTDEC = 2'h3;
  // Register port word indexes
  localparam logic [3:0] REG_WORKING = 4'h0;
  localparam logic [3:0] REG_BANK = 4'h1;
  localparam logic [3:0] REG_PCLATCH = 4'h2;
  localparam logic [3:0] REG_OPTION = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_POWER = 4'h5;
  localparam logic [3:0] REG_IRQCTL = 4'h6;
  localparam logic [3:0] REG_PTR0_LO = 4'h7;
  localparam logic [3:0] REG_PTR0_HI = 4'h8;
  localparam logic [3:0] REG_PTR1_LO = 4'h9;
  localparam logic [3:0] REG_PTR1_HI = 4'hA;
  localparam logic [3:0] REG_PC_LO = 4'hB;
  localparam logic [3:0] REG_PC_HI = 4'hC;
  // Bit positions and reset values
  localparam int IRQ_EN_BIT = 7;
  localparam int RI_FLAG_N_BIT = 2;
  localparam logic [7:0] RST_OPTION = 8'hFF;
  localparam logic [7:0] RST_POWER = 8'h1C;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [14:0] RST_PC = 15'h0000;
  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } mre_state_e;
endpackage

/* verilog/mre_exec.sv */
// Executes the move/load/return group of an 8-bit core, one word per cycle, two cycles for a return.
// Assumes program memory on clk presents words with instr_valid, honours
// instr_ready, and that the data memory and stack sit outside this block.
`timescale 1ns/100ps
`default_nettype none
module mre_exec
  import mre_pkg::*;
#(
  parameter int PTR_W = 16,
  parameter int BANK_W = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Instruction stream
  input wire logic instr_valid,
  input wire logic [13:0] instr_data,
  output logic instr_ready,
  output logic [14:0] pc_out,
  // Hardware stack
  input wire logic [14:0] stack_top,
  output logic stack_pop,
  // Data memory write port
  output logic mem_wr_en,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Reset request to the rest of the device
  output logic soft_reset_pulse
);

  mre_state_e state_reg;
  logic [7:0] working_reg;
  logic [BANK_W-1:0] bank_select_reg;
  logic [6:0] pc_high_latch;
  logic [7:0] option_reg;
  logic [7:0] status_reg;
  logic [7:0] power_control_reg;
  logic [7:0] irq_control_reg;
  logic [PTR_W-1:0] indirect_pointer [2];
  logic [14:0] pc_reg;

  // Decode
  logic take;
  logic is_idle, is_reset, is_ret, is_retirq, is_option;
  logic is_st_ind, is_st_rel, is_st_file, is_ld_bank, is_ld_page, is_ld_work;
  logic sel;
  logic [1:0] pointer_mode_field;
  logic signed [5:0] rel_off;
  logic [PTR_W-1:0] ptr_cur, ptr_inc, ptr_dec, ptr_rel, ptr_next, eff_addr;
  logic sw_reset;

  assign instr_ready = (state_reg == ST_EXEC);
  assign take = instr_valid && instr_ready;
  assign is_idle = take && (instr_data == OP_IDLE);
  assign is_reset = take && (instr_data == OP_RESET);
  assign is_ret = take && (instr_data == OP_RETURN);
  assign is_retirq = take && (instr_data == OP_RETIRQ);
  assign is_option = take && (instr_data == OP_OPTION);
  assign is_st_ind = take && ((instr_data & MSK_ST_IND) == OP_ST_IND);
  assign is_st_rel = take && ((instr_data & MSK_ST_REL) == OP_ST_REL);
  assign is_st_file = take && ((instr_data & MSK_ST_FILE) == OP_ST_FILE);
  assign is_ld_bank = take && ((instr_data & MSK_LD_BANK) == OP_LD_BANK);
  assign is_ld_page = take && ((instr_data & MSK_LD_PAGE) == OP_LD_PAGE);
  assign is_ld_work = take && ((instr_data & MSK_LD_WORK) == OP_LD_WORK);
  assign sw_reset = is_reset;

  assign sel = is_st_rel ? instr_data[SEL_BIT_REL] : instr_data[SEL_BIT_PLAIN];
  assign pointer_mode_field = instr_data[1:0];
  assign rel_off = instr_data[5:0];
  assign ptr_cur = indirect_pointer[sel];
  // Plain modular arithmetic gives the wrap at both ends for free
  assign ptr_inc = ptr_cur + PTR_W'(1); // [RL9]
  assign ptr_dec = ptr_cur - PTR_W'(1); // [RL9]
  assign ptr_rel = ptr_cur + PTR_W'(signed'(rel_off)); // [RL7]

  // Effective address and pointer after the store
  always_comb begin
    eff_addr = ptr_cur;
    ptr_next = ptr_cur;
    if (is_st_rel) begin
      eff_addr = ptr_rel; // [RL7]
    end else begin
      case (pointer_mode_field) // [RL6]
        MODE_PREINC: begin
          eff_addr = ptr_inc;
          ptr_next = ptr_inc;
        end
        MODE_PREDEC: begin
          eff_addr = ptr_dec;
          ptr_next = ptr_dec;
        end
        MODE_POSTINC: begin
          eff_addr = ptr_cur;
          ptr_next = ptr_inc;
        end
        MODE_POSTDEC: begin
          eff_addr = ptr_cur;
          ptr_next = ptr_dec;
        end
        default: begin
          eff_addr = ptr_cur;
          ptr_next = ptr_cur;
        end
      endcase
    end
  end

  // Sequencer: returns hold off the next word for one cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_EXEC;
    end else begin
      case (state_reg)
        ST_EXEC: begin
          if (is_ret || is_retirq) begin
            state_reg <= ST_FLUSH; // [RL13] [RL14]
          end
        end
        ST_FLUSH: begin
          state_reg <= ST_EXEC;
        end
        default: begin
          state_reg <= ST_EXEC;
        end
      endcase
    end
  end

  // Program counter; taken words advance it, returns reload it, software reset clears it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_reg <= RST_PC;
    end else if (sw_reset) begin
      pc_reg <= RST_PC; // [RL12]
    end else if (is_ret || is_retirq) begin
      pc_reg <= stack_top; // [RL13] [RL14]
    end else if (take) begin
      pc_reg <= pc_reg + 15'h0001; // [RL15]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stack_pop <= 1'b0;
      soft_reset_pulse <= 1'b0;
    end else begin
      stack_pop <= is_ret || is_retirq; // [RL13] [RL14]
      soft_reset_pulse <= sw_reset; // [RL12]
    end
  end

  // Working register: literal load beats a same-cycle software write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      working_reg <= 8'h00;
    end else if (sw_reset) begin
      working_reg <= 8'h00;
    end else if (is_ld_work) begin
      working_reg <= instr_data[7:0]; // [RL3]
    end else if (reg_wr && reg_addr == REG_WORKING) begin
      working_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bank_select_reg <= '0;
    end else if (sw_reset) begin
      bank_select_reg <= '0;
    end else if (is_ld_bank) begin
      bank_select_reg <= instr_data[BANK_W-1:0]; // [RL1]
    end else if (reg_wr && reg_addr == REG_BANK) begin
      bank_select_reg <= reg_wdata[BANK_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pc_high_latch <= 7'h00;
    end else if (sw_reset) begin
      pc_high_latch <= 7'h00;
    end else if (is_ld_page) begin
      pc_high_latch <= instr_data[6:0]; // [RL2]
    end else if (reg_wr && reg_addr == REG_PCLATCH) begin
      pc_high_latch <= reg_wdata[6:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      option_reg <= RST_OPTION;
    end else if (sw_reset) begin
      option_reg <= RST_OPTION;
    end else if (is_option) begin
      option_reg <= working_reg; // [RL11]
    end else if (reg_wr && reg_addr == REG_OPTION) begin
      option_reg <= reg_wdata;
    end
  end

  // Status flags: only the software reset of this group touches them, loading RST_STATUS
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= RST_STATUS;
    end else if (sw_reset) begin
      status_reg <= RST_STATUS;
    end else if (reg_wr && reg_addr == REG_STATUS) begin
      status_reg <= reg_wdata; // [RL10]
    end
  end

  // Power control survives the software reset so the cause stays readable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_control_reg <= RST_POWER;
    end else if (sw_reset) begin
      power_control_reg[RI_FLAG_N_BIT] <= 1'b0; // [RL12]
    end else if (reg_wr && reg_addr == REG_POWER) begin
      power_control_reg <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_control_reg <= 8'h00;
    end else if (sw_reset) begin
      irq_control_reg <= 8'h00;
    end else if (is_retirq) begin
      irq_control_reg[IRQ_EN_BIT] <= 1'b1; // [RL13]
    end else if (reg_wr && reg_addr == REG_IRQCTL) begin
      irq_control_reg <= reg_wdata;
    end
  end

  // Indirect pointers; relative form leaves the pointer as it was
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      indirect_pointer[0] <= '0;
      indirect_pointer[1] <= '0;
    end else if (sw_reset) begin
      indirect_pointer[0] <= '0;
      indirect_pointer[1] <= '0;
    end else if (is_st_ind) begin
      indirect_pointer[sel] <= ptr_next; // [RL8]
    end else if (reg_wr) begin
      case (reg_addr)
        REG_PTR0_LO: indirect_pointer[0][7:0] <= reg_wdata;
        REG_PTR0_HI: indirect_pointer[0][PTR_W-1:8] <= reg_wdata[PTR_W-9:0];
        REG_PTR1_LO: indirect_pointer[1][7:0] <= reg_wdata;
        REG_PTR1_HI: indirect_pointer[1][PTR_W-1:8] <= reg_wdata[PTR_W-9:0];
        default: begin
        end
      endcase
    end
  end

  // Data memory write, registered so the write lands after decode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mem_wr_en <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      mem_wr_en <= is_st_file || is_st_ind || is_st_rel; // [RL4] [RL5]
      mem_wdata <= working_reg; // [RL4] [RL5]
      if (is_st_file) begin
        mem_addr <= 16'({bank_select_reg, instr_data[6:0]}); // [RL4]
      end else if (is_st_ind || is_st_rel) begin
        mem_addr <= 16'(eff_addr); // [RL5]
      end
    end
  end

  // Register read, answered in the next cycle; unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_WORKING: reg_rdata <= working_reg;
        REG_BANK: reg_rdata <= 8'(bank_select_reg);
        REG_PCLATCH: reg_rdata <= {1'b0, pc_high_latch};
        REG_OPTION: reg_rdata <= option_reg;
        REG_STATUS: reg_rdata <= status_reg;
        REG_POWER: reg_rdata <= power_control_reg;
        REG_IRQCTL: reg_rdata <= irq_control_reg;
        REG_PTR0_LO: reg_rdata <= indirect_pointer[0][7:0];
        REG_PTR0_HI: reg_rdata <= 8'(indirect_pointer[0][PTR_W-1:8]);
        REG_PTR1_LO: reg_rdata <= indirect_pointer[1][7:0];
        REG_PTR1_HI: reg_rdata <= 8'(indirect_pointer[1][PTR_W-1:8]);
        REG_PC_LO: reg_rdata <= pc_reg[7:0];
        REG_PC_HI: reg_rdata <= {1'b0, pc_reg[14:8]};
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  assign pc_out = pc_reg;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  bank_load_a: assert property (is_ld_bank |=> // [RL1]
      bank_select_reg == $past(instr_data[BANK_W-1:0]) && $stable(status_reg))
    else $error("bank select not loaded");
  page_load_a: assert property (is_ld_page |=> // [RL2]
      pc_high_latch == $past(instr_data[6:0]))
    else $error("pc high latch not loaded");
  work_load_a: assert property (is_ld_work |=> // [RL3]
      working_reg == $past(instr_data[7:0]) && instr_ready && $stable(status_reg))
    else $error("working literal load wrong");
  file_store_a: assert property (is_st_file |=> // [RL4]
      mem_wr_en && mem_wdata == $past(working_reg)
      && mem_addr[6:0] == $past(instr_data[6:0]))
    else $error("file store wrong");
  ind_store_a: assert property (is_st_ind && pointer_mode_field == MODE_PREINC |=> // [RL6]
      mem_wr_en && mem_addr == 16'($past(ptr_cur) + PTR_W'(1))
      && indirect_pointer[$past(sel)] == mem_addr)
    else $error("preincrement store wrong");
  post_dec_a: assert property (is_st_ind && pointer_mode_field == MODE_POSTDEC |=> // [RL8]
      mem_addr == 16'($past(ptr_cur))
      && indirect_pointer[$past(sel)] == $past(ptr_cur) - PTR_W'(1))
    else $error("postdecrement store wrong");
  rel_keep_a: assert property (is_st_rel |=> // [RL7]
      indirect_pointer[$past(sel)] == $past(ptr_cur)
      && mem_addr == 16'($past(ptr_cur) + PTR_W'(signed'($past(rel_off)))))
    else $error("relative store wrong");
  ptr_flags_a: assert property (is_st_ind || is_st_rel |=> // [RL10]
      $stable(status_reg))
    else $error("indirect store changed flags");
  option_load_a: assert property (is_option |=> // [RL11]
      option_reg == $past(working_reg))
    else $error("option not loaded");
  soft_reset_a: assert property (is_reset |=> // [RL12]
      soft_reset_pulse && !power_control_reg[RI_FLAG_N_BIT] && pc_reg == RST_PC)
    else $error("software reset wrong");
  irq_return_a: assert property (is_retirq |=> // [RL13]
      irq_control_reg[IRQ_EN_BIT] && pc_reg == $past(stack_top) && stack_pop
      && !instr_ready ##1 instr_ready)
    else $error("irq return wrong");
  sub_return_a: assert property (is_ret |=> // [RL14]
      pc_reg == $past(stack_top) && stack_pop && !instr_ready ##1 instr_ready)
    else $error("subroutine return wrong");
  nop_idle_a: assert property (is_idle |=> // [RL15]
      pc_reg == $past(pc_reg) + 15'h0001 && !mem_wr_en && $stable(working_reg)
      && $stable(status_reg) && instr_ready)
    else $error("no-operation changed state");

endmodule
`default_nettype wire

/* tb/mre_prog_mem.sv */
// Program memory model that feeds the executor one word at a time.
// Assumes the bench queues words with push and sets gap for slow fetches.
`timescale 1ns/100ps
`default_nettype none
module mre_prog_mem (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Fetch handshake
  input wire logic instr_ready,
  input wire logic [3:0] gap,
  output var logic instr_valid,
  output var logic [13:0] instr_data
);
  logic [13:0] q[$];
  logic [3:0] idle_cnt;
  task automatic push(input logic [13:0] w);
    q.push_back(w);
  endtask
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      instr_valid <= 1'b0;
      instr_data <= 14'h2AAA;
      idle_cnt <= 4'h0;
    end else if (instr_valid && !instr_ready) begin
      // Word held until the executor takes it
    end else if (q.size() != 0 && idle_cnt >= gap) begin
      instr_valid <= 1'b1;
      instr_data <= q.pop_front();
      idle_cnt <= 4'h0;
    end else begin
      // Idle word toggles so a stale one never looks valid
      instr_valid <= 1'b0;
      instr_data <= ~instr_data;
      idle_cnt <= idle_cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* tb/move_return_instr_exec_bench.sv */
// Self-checking bench for the move/return executor.
// Assumes the program memory model, the register port and stack_top as the only stimulus.
`timescale 1ns/100ps
`default_nettype none
module move_return_instr_exec_bench import mre_pkg::*; ();
  logic clk, reset_n, instr_ready, instr_valid, stack_pop, mem_wr_en;
  logic reg_wr, reg_rd, soft_reset_pulse;
  logic [13:0] instr_data;
  logic [14:0] pc_out, stack_top;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata, reg_wdata, reg_rdata;
  logic [3:0] reg_addr, gap;
  logic [23:0] wr_q[$];
  logic [7:0] rst_exp [7] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h18, 8'h1C, 8'h00};
  logic [15:0] ind_exp [4] = '{16'h0000, 16'hFFFF, 16'hFFFF, 16'h0000};
  logic [15:0] ptr_exp [4] = '{16'h0000, 16'hFFFF, 16'h0000, 16'hFFFF};
  logic [5:0] k_tab [3] = '{6'h20, 6'h1F, 6'h00};
  logic [15:0] k_adr [3] = '{16'hFFF0, 16'h002F, 16'h0010};
  int failures, total_checks, pops, soft_cnt;

  mre_exec i_dut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_data(instr_data), .instr_ready(instr_ready), .pc_out(pc_out),
    .stack_top(stack_top), .stack_pop(stack_pop), .mem_wr_en(mem_wr_en),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .soft_reset_pulse(soft_reset_pulse));
  mre_prog_mem i_mem (.clk(clk), .reset_n(reset_n), .instr_ready(instr_ready),
    .gap(gap), .instr_valid(instr_valid), .instr_data(instr_data));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (mem_wr_en === 1'b1) wr_q.push_back({mem_addr, mem_wdata});
    if (stack_pop === 1'b1) pops++;
    if (soft_reset_pulse === 1'b1) soft_cnt++;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // One idle edge so the next call never reassigns the strobe in this step
    @(posedge clk);
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    // Data stands in this cycle; taken at the edge that closes it
    @(posedge clk);
    d = reg_rdata;
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] v;
    reg_read(a, v);
    check($sformatf("reg %h", a), {8'h00, v}, {8'h00, e});
  endtask

  task automatic set_ptr(input int n, input logic [15:0] v);
    reg_write(REG_PTR0_LO + 4'(2 * n), v[7:0]);
    reg_write(REG_PTR0_LO + 4'(2 * n + 1), v[15:8]);
  endtask

  task automatic chk_ptr(input int n, input logic [15:0] e);
    logic [7:0] lo, hi;
    reg_read(REG_PTR0_LO + 4'(2 * n), lo);
    reg_read(REG_PTR0_LO + 4'(2 * n + 1), hi);
    check("pointer", {hi, lo}, e);
  endtask

  task automatic settle();
    int n = 0;
    while ((i_mem.q.size() != 0 || instr_valid === 1'b1) && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n >= 100) failures++;
    repeat (2) @(posedge clk);
  endtask

  task automatic run(input logic [13:0] w);
    i_mem.push(w);
    settle();
  endtask

  task automatic exp_wr(input logic [15:0] a, input logic [7:0] d);
    logic [23:0] e;
    e = (wr_q.size() != 0) ? wr_q.pop_front() : 24'hxx_xxxx;
    check("write addr", e[23:8], a);
    check("write data", {8'h00, e[7:0]}, {8'h00, d});
  endtask

  initial begin
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    gap = 4'h0;
    stack_top = 15'h6ABC;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 7; i++) chk_reg(4'(i), rst_exp[i]);
    reg_write(4'hF, 8'h55);
    chk_reg(4'hF, 8'h00);
    run(14'h30FF);
    chk_reg(REG_WORKING, 8'hFF);
    run(14'h002F);
    chk_reg(REG_BANK, 8'h0F);
    run(14'h31FF);
    chk_reg(REG_PCLATCH, 8'h7F);
    // Store right behind the load must see the new working value
    i_mem.push(14'h305A);
    i_mem.push(14'h00FF);
    settle();
    exp_wr(16'h07FF, 8'h5A);
    check("pc", {1'b0, pc_out}, 16'h0005);
    chk_reg(REG_STATUS, 8'h18);
    run(14'h0062);
    chk_reg(REG_OPTION, 8'h5A);
    run(14'h0000);
    check("pc", {1'b0, pc_out}, 16'h0007);
    check("writes", 16'(wr_q.size()), 16'h0000);
    chk_reg(REG_WORKING, 8'h5A);
    // Start both pointers at the top so every mode crosses a wrap
    set_ptr(0, 16'hFFFF);
    set_ptr(1, 16'hFFFF);
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 4; m++) begin
        run(14'h0018 | 14'(n * 4 + m));
        exp_wr(ind_exp[m], 8'h5A);
        chk_ptr(n, ptr_exp[m]);
      end
    end
    chk_reg(REG_STATUS, 8'h18);
    set_ptr(1, 16'h0010);
    for (int i = 0; i < 3; i++) begin
      run(14'h3FC0 | {8'h00, k_tab[i]});
      exp_wr(k_adr[i], 8'h5A);
      chk_ptr(1, 16'h0010);
    end
    // Word queued right behind a return must wait, not vanish
    i_mem.push(14'h0008);
    i_mem.push(14'h3033);
    settle();
    check("pops", 16'(pops), 16'h0001);
    check("pc", {1'b0, pc_out}, 16'h6ABD);
    chk_reg(REG_WORKING, 8'h33);
    gap <= 4'h2;
    stack_top <= 15'h0123;
    run(14'h0009);
    check("pops", 16'(pops), 16'h0002);
    check("pc", {1'b0, pc_out}, 16'h0123);
    chk_reg(REG_IRQCTL, 8'h80);
    chk_reg(REG_STATUS, 8'h18);
    gap <= 4'h0;
    run(14'h0001);
    check("soft pulses", 16'(soft_cnt), 16'h0001);
    for (int i = 0; i < 7; i++) chk_reg(4'(i), (i == 5) ? 8'h18 : rst_exp[i]);
    chk_ptr(1, 16'h0000);
    print_verdict();
  end

  initial begin
    #160000;
    failures++;
    print_verdict();
  end
endmodule
`default_nettype wire
